// >>> eint_consts.svh
// Constants of the external pin interrupt unit: offsets, reset values, field positions.
// Assumes inclusion by bare name from every design file that needs a figure.
//
// Summary of operation
// [RULE_01] A line requests even when its pin is driven as an output.
// [RULE_02] Sense select 00 low level, 01 any change, 10 falling, 11 rising.
// [RULE_03] Enabled low-level line requests for as long as pin stays low.
// [RULE_04] Edge and change detection need the I/O clock; level detection does not.
// [RULE_05] Power-down wake samples pin twice on watchdog clock ticks.
// [RULE_06] Level vanished before start-up end still wakes, without an interrupt.
// [RULE_07] A line activates only with global enable and its mask bit set.
// [RULE_08] Pin is sampled before edge detection; pulses over one clock caught.
// [RULE_09] Source holds low level until the current instruction completes.
// [RULE_10] Software clears a line's enable before changing its sense bits.
// [RULE_11] Edge or change request sets the line's pending flag.
// [RULE_12] Pending, enable and global enable set gives the line's vector request.
// [RULE_13] Pending clears on routine entry and on software writing one.
// [RULE_14] In low-level mode the pending flag always reads cleared.
// [RULE_15] Sense control is 8 bits RW, reset zero, line 3 in top pair.
// [RULE_16] Enable mask holds one bit per line in low four bits, reset zero.
// [RULE_17] Edges compare current and previous registered samples on the I/O clock.
`ifndef EINT_CONSTS_SVH
`define EINT_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define EINT_ADDR_W 12
`define EINT_OFF_SENSE 12'h000
`define EINT_OFF_MASK 12'h004
`define EINT_OFF_FLAGS 12'h008
`define EINT_SENSE_RST 8'h00
`define EINT_MASK_RST 4'h0
`define EINT_FLAGS_RST 4'h0
`define EINT_SAMPLE_RST 4'hF
`define EINT_PRDATA_RST 32'h00000000
`define EINT_LINES 4
`define EINT_SEL_W 2
`define EINT_MASK_MSB 3
`define EINT_REG_MSB 7
`define EINT_ZERO24 24'h000000
`define EINT_ZERO28 28'h0000000

`endif

// >>> eint_pkg.sv
// Types shared by the external pin interrupt unit.
// Assumes nothing beyond a SystemVerilog compiler.
package eint_pkg;
    typedef enum logic [1:0]
    {
        EINT_SENSE_LOW,
        EINT_SENSE_ANY,
        EINT_SENSE_FALL,
        EINT_SENSE_RISE
    } eint_sense_t;

    typedef enum logic [1:0]
    {
        EINT_WK_IDLE,
        EINT_WK_ONE,
        EINT_WK_WAKE
    } eint_wake_t;
endpackage

// >>> eint_line_if.sv
// Carrier between the register core and the detection modules.
// Assumes one clock domain; all members are driven by flip-flops or simple decodes.
interface eint_line_if;
    logic [7:0] sense;
    logic [3:0] enable;
    logic [3:0] edge_event;
    logic io_clk_run;
    logic wake;

    modport core
    (
        output sense,
        output enable,
        output io_clk_run,
        input edge_event,
        input wake
    );

    modport det
    (
        input sense,
        input enable,
        input io_clk_run,
        output edge_event
    );

    modport wk
    (
        input sense,
        input enable,
        output wake
    );
endinterface

// >>> eint_edge_det.sv
// Pin sampler and per-line edge detector.
// Assumes pins are synchronous to the clock and the I/O clock run level gates detection.
`include "eint_consts.svh"
module eint_edge_det
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins and carrier
    input wire logic [3:0] pins,
    eint_line_if.det lif
);
    logic [3:0] cur_reg;
    logic [3:0] prev_reg;

    // ----------------------------------------------------------------
    // Sampling
    // ----------------------------------------------------------------
    // Samples freeze while the I/O clock is halted, so no edge is seen asleep.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur_reg <= `EINT_SAMPLE_RST;
            prev_reg <= `EINT_SAMPLE_RST;
        end
        else if (lif.io_clk_run) // [RULE_04]
        begin
            cur_reg <= pins; // [RULE_08]
            prev_reg <= cur_reg; // [RULE_17]
        end
    end

    // ----------------------------------------------------------------
    // Per-line decode
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `EINT_LINES; g = g + 1)
        begin : g_line
            wire [1:0] sel = lif.sense[`EINT_SEL_W*g +: `EINT_SEL_W];
            wire rise = cur_reg[g] & ~prev_reg[g];
            wire fall = ~cur_reg[g] & prev_reg[g];
            wire hit_any = (sel == eint_pkg::EINT_SENSE_ANY) & (rise | fall);
            wire hit_fall = (sel == eint_pkg::EINT_SENSE_FALL) & fall;
            wire hit_rise = (sel == eint_pkg::EINT_SENSE_RISE) & rise;
            assign lif.edge_event[g] = lif.io_clk_run & (hit_any | hit_fall | hit_rise); // [RULE_02] [RULE_17]
        end
    endgenerate
endmodule

// >>> eint_wake.sv
// Low-level wake detector for power-down, sampled on watchdog oscillator ticks.
// Assumes the tick is a one-cycle pulse synchronous to the clock.
`include "eint_consts.svh"
module eint_wake
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Sleep control
    input wire logic power_down,
    input wire logic wdt_tick,
    input wire logic [3:0] pins,
    eint_line_if.wk lif
);
    eint_pkg::eint_wake_t state_reg;
    eint_pkg::eint_wake_t state_next;
    logic [3:0] lvl_on;
    logic low_seen;

    genvar g;
    generate
        for (g = 0; g < `EINT_LINES; g = g + 1)
        begin : g_lvl
            assign lvl_on[g] = lif.enable[g] & (lif.sense[`EINT_SEL_W*g +: `EINT_SEL_W] == eint_pkg::EINT_SENSE_LOW)
                & ~pins[g];
        end
    endgenerate

    assign low_seen = |lvl_on;

    // Wake is held once two ticks saw the level; the interrupt itself only follows
    // if the pin is still low after start-up, which the core checks on its own.
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            eint_pkg::EINT_WK_IDLE:
                if (power_down && wdt_tick && low_seen)
                    state_next = eint_pkg::EINT_WK_ONE;
            eint_pkg::EINT_WK_ONE:
                if (!power_down)
                    state_next = eint_pkg::EINT_WK_IDLE;
                else if (wdt_tick)
                    state_next = low_seen ? eint_pkg::EINT_WK_WAKE : eint_pkg::EINT_WK_IDLE; // [RULE_05]
            eint_pkg::EINT_WK_WAKE:
                if (!power_down)
                    state_next = eint_pkg::EINT_WK_IDLE; // [RULE_06]
            default:
                state_next = eint_pkg::EINT_WK_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state_reg <= eint_pkg::EINT_WK_IDLE;
        else
            state_reg <= state_next;
    end

    assign lif.wake = (state_reg == eint_pkg::EINT_WK_WAKE);
endmodule

// >>> eint_top.sv
// External pin interrupt unit: APB registers, pending flags, requests and wake.
// Assumes APB master on CORE_CLK, pins synchronous to CORE_CLK, pad value read back
// even when the port drives the pin.
//
// The implementer's own choices: register access over APB and the address map.
`include "eint_consts.svh"
module eint_top
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Pins
    input wire logic [3:0] EXT_IRQ_PINS,
    // Core interface
    input wire logic GLOBAL_INT_EN,
    input wire logic IO_CLK_RUN,
    input wire logic POWER_DOWN,
    input wire logic WDT_TICK,
    input wire logic VECTOR_ACK,
    input wire logic [1:0] VECTOR_ACK_LINE,
    output logic [3:0] LINE_IRQ_REQ,
    output logic IRQ,
    output logic WAKE_REQ
);
    logic [7:0] sense_reg;
    logic [3:0] enable_reg;
    logic [3:0] flags_reg;
    logic [3:0] flags_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic [3:0] level_mode;
    logic [3:0] level_req;
    logic [3:0] edge_req;
    logic [3:0] ack_clr;
    logic [3:0] sw_clr;
    logic [3:0] flags_vis;

    eint_line_if lif ();

    // ----------------------------------------------------------------
    // Detection modules
    // ----------------------------------------------------------------
    eint_edge_det u_det
    (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .pins(EXT_IRQ_PINS), // [RULE_01]
        .lif(lif.det)
    );

    eint_wake u_wake
    (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .power_down(POWER_DOWN),
        .wdt_tick(WDT_TICK),
        .pins(EXT_IRQ_PINS),
        .lif(lif.wk)
    );

    assign lif.sense = sense_reg;
    assign lif.enable = enable_reg;
    assign lif.io_clk_run = IO_CLK_RUN;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire setup = PSEL & ~PENABLE;
    wire access = PSEL & PENABLE;
    wire hit_sense = (PADDR == `EINT_OFF_SENSE);
    wire hit_mask = (PADDR == `EINT_OFF_MASK);
    wire hit_flags = (PADDR == `EINT_OFF_FLAGS);
    wire hit_any = hit_sense | hit_mask | hit_flags;
    wire wr = access & PWRITE & hit_any;
    wire wr_sense = wr & hit_sense;
    wire wr_mask = wr & hit_mask;
    wire wr_flags = wr & hit_flags;

    // Zero wait states: read data is captured in the setup cycle so that it can
    // come from a flip-flop and still be ready at the first access edge.
    assign PREADY = 1'b1;
    assign PSLVERR = access & ~hit_any;
    assign PRDATA = prdata_reg;

    // ----------------------------------------------------------------
    // Pending flags
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `EINT_LINES; g = g + 1)
        begin : g_line
            assign level_mode[g] = (sense_reg[`EINT_SEL_W*g +: `EINT_SEL_W] == eint_pkg::EINT_SENSE_LOW);
            assign ack_clr[g] = VECTOR_ACK & (VECTOR_ACK_LINE == 2'(g)); // [RULE_13]
            assign sw_clr[g] = wr_flags & PWDATA[g]; // [RULE_13]
            // Set wins over either clear so an event in the clearing cycle survives.
            assign flags_next[g] = level_mode[g] ? 1'b0 :
                lif.edge_event[g] ? 1'b1 : // [RULE_11]
                (ack_clr[g] | sw_clr[g]) ? 1'b0 : flags_reg[g]; // [RULE_14]
            assign flags_vis[g] = flags_reg[g] & ~level_mode[g]; // [RULE_14]
            // Level requests follow the pin itself, so they need no I/O clock.
            assign level_req[g] = level_mode[g] & ~EXT_IRQ_PINS[g]; // [RULE_03] [RULE_04]
            assign edge_req[g] = flags_vis[g];
            assign LINE_IRQ_REQ[g] = GLOBAL_INT_EN & enable_reg[g] & (level_req[g] | edge_req[g]); // [RULE_07] [RULE_12]
        end
    endgenerate

    assign IRQ = |LINE_IRQ_REQ;
    assign WAKE_REQ = lif.wake; // [RULE_05] [RULE_06]

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    always_comb
    begin
        prdata_next = prdata_reg;
        if (setup && !PWRITE)
        begin
            if (hit_sense)
                prdata_next = {`EINT_ZERO24, sense_reg};
            else if (hit_mask)
                prdata_next = {`EINT_ZERO28, enable_reg};
            else if (hit_flags)
                prdata_next = {`EINT_ZERO28, flags_vis};
            else
                prdata_next = `EINT_PRDATA_RST;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Software is expected to drop a line's enable before retyping its sense bits;
    // nothing here filters the glitch a live change can cause.
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sense_reg <= `EINT_SENSE_RST;
            enable_reg <= `EINT_MASK_RST;
            flags_reg <= `EINT_FLAGS_RST;
            prdata_reg <= `EINT_PRDATA_RST;
        end
        else
        begin
            if (wr_sense)
                sense_reg <= PWDATA[`EINT_REG_MSB:0]; // [RULE_15]
            if (wr_mask)
                enable_reg <= PWDATA[`EINT_MASK_MSB:0]; // [RULE_16]
            flags_reg <= flags_next;
            prdata_reg <= prdata_next;
        end
    end
endmodule

// >>> eint_core_model.sv
// Core-side model: enters the routine of the lowest requesting line.
// Assumes requests are levels on the unit's clock.
module eint_core_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Requests and routine entry
    input wire logic auto_en,
    input wire logic [3:0] line_req,
    output logic ack,
    output logic [1:0] ack_line
);
    wire [1:0] pick = line_req[0] ? 2'h0 : line_req[1] ? 2'h1 : line_req[2] ? 2'h2 : 2'h3;
    // One idle cycle after each entry, so a flag being cleared is not entered twice.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ack <= 1'h0;
        else
            ack <= auto_en && !ack && line_req != 4'h0;
    end
    always_ff @(posedge clk)
    begin
        ack_line <= pick;
    end
endmodule

// >>> eint_checker.sv
// Assertions on the ports of the external pin interrupt unit.
// Assumes writes land at PSEL and PENABLE; shadows follow sense and enable.
`include "eint_consts.svh"
module eint_checker
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // APB
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    // Pins and core
    input wire logic [3:0] EXT_IRQ_PINS,
    input wire logic GLOBAL_INT_EN,
    input wire logic IO_CLK_RUN,
    input wire logic WDT_TICK,
    input wire logic POWER_DOWN,
    input wire logic VECTOR_ACK,
    input wire logic [1:0] VECTOR_ACK_LINE,
    input wire logic [3:0] LINE_IRQ_REQ,
    input wire logic IRQ,
    input wire logic WAKE_REQ
);
    // ----------------------------------------------------------------
    // Shadow registers and properties
    // ----------------------------------------------------------------
    logic [7:0] sense_reg;
    logic [3:0] en_reg;
    wire wr_go = PSEL && PENABLE && PWRITE;
    wire lvl0 = GLOBAL_INT_EN && en_reg[0] && sense_reg[1:0] == 2'h0;
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            sense_reg <= 8'h00;
        else if (wr_go && PADDR == `EINT_OFF_SENSE)
            sense_reg <= PWDATA[7:0];
    end
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            en_reg <= 4'h0;
        else if (wr_go && PADDR == `EINT_OFF_MASK)
            en_reg <= PWDATA[3:0];
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    AST_IRQ_OR: assert property (IRQ == (|LINE_IRQ_REQ))
        else $error("IRQ differs from the line requests");
    AST_GATE: assert property (LINE_IRQ_REQ != 4'h0 |-> GLOBAL_INT_EN && (LINE_IRQ_REQ & ~en_reg) == 4'h0)
        else $error("request without enables");
    AST_LEVEL: assert property (lvl0 && !EXT_IRQ_PINS[0] |-> LINE_IRQ_REQ[0])
        else $error("low level without request");
    AST_LVL_CLR: assert property (lvl0 && EXT_IRQ_PINS[0] |-> !LINE_IRQ_REQ[0])
        else $error("level mode request with pin high");
    AST_FALL: assert property (GLOBAL_INT_EN && en_reg[2] && sense_reg[5:4] == 2'h2 && IO_CLK_RUN
        && $fell(EXT_IRQ_PINS[2]) |-> ##[1:2] LINE_IRQ_REQ[2])
        else $error("falling edge missed");
    AST_ACK_CLR: assert property (VECTOR_ACK && VECTOR_ACK_LINE == 2'h0 && sense_reg[1:0] != 2'h0
        && $stable(EXT_IRQ_PINS[0]) && $past(EXT_IRQ_PINS[0]) == $past(EXT_IRQ_PINS[0], 2) |=> !LINE_IRQ_REQ[0])
        else $error("flag not cleared on entry");
    AST_SENSE_RD: assert property (PSEL && PENABLE && !PWRITE && PADDR == `EINT_OFF_SENSE
        |-> PRDATA == {24'h000000, sense_reg})
        else $error("sense readback wrong");
    AST_WAKE: assert property ($rose(WAKE_REQ) |-> $past(POWER_DOWN) && $past(WDT_TICK))
        else $error("wake without tick");
endmodule
bind eint_top eint_checker u_chk (.CORE_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .EXT_IRQ_PINS, .GLOBAL_INT_EN, .IO_CLK_RUN, .WDT_TICK, .POWER_DOWN, .VECTOR_ACK, .VECTOR_ACK_LINE,
    .LINE_IRQ_REQ, .IRQ, .WAKE_REQ);

// >>> tb_top.sv
// Self-checking bench for the external pin interrupt unit.
// Assumes design, core model and checker are compiled first.
`include "eint_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Signals, instances and tasks
    // ----------------------------------------------------------------
    logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0, gie = 1'h0;
    logic ioclk = 1'h1, pd = 1'h0, tick = 1'h0, auto_en = 1'h0, pready, pslverr, irq, wake, ack;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pins = 4'hF, req, f;
    logic [1:0] ack_line;
    logic [32:0] exp_q[$];
    logic [15:0] rnd = 16'h9687;
    int err_total = 0, num_checks = 0;
    eint_top dut (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EXT_IRQ_PINS(pins),
        .GLOBAL_INT_EN(gie), .IO_CLK_RUN(ioclk), .POWER_DOWN(pd), .WDT_TICK(tick), .VECTOR_ACK(ack),
        .VECTOR_ACK_LINE(ack_line), .LINE_IRQ_REQ(req), .IRQ(irq), .WAKE_REQ(wake));
    eint_core_model core (.clk(clk), .rst_n(rst_n), .auto_en(auto_en), .line_req(req), .ack(ack),
        .ack_line(ack_line));
    initial
    begin
        forever #20 clk = ~clk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic fail(input string m);
        err_total++;
        $display("ERROR at %0t: %s", $time, m);
    endtask
    // Outputs are read at the falling edge, after every launch of the last rising edge has settled.
    task automatic chk(input int sel, input logic [3:0] exp, input string m);
        logic [3:0] got;
        @(negedge clk);
        got = (sel == 0) ? req : (sel == 1) ? {irq, req[2:0]} : {3'h0, wake};
        num_checks++;
        if (got !== exp)
            fail(m);
        @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        int n;
        if (!w)
            exp_q.push_back(e);
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge clk);
            if (pready === 1'h1)
                break;
        end
        psel <= 1'h0;
        pen <= 1'h0;
        if (n == 16)
        begin
            fail("bus wait ran out");
            print_verdict();
        end
    endtask
    task automatic pulse_tick();
        @(posedge clk);
        tick <= 1'h1;
        @(posedge clk);
        tick <= 1'h0;
    endtask
    // Reads are judged here, apart from the driver, in the order they were issued.
    always @(posedge clk)
    begin
        if (psel && pen && !pwr && pready === 1'h1)
        begin
            num_checks++;
            if (exp_q.size() == 0 || {pslverr, prdata} !== exp_q[0])
                fail("read response mismatch");
            if (exp_q.size() != 0)
                void'(exp_q.pop_front());
        end
    end
    initial
    begin
        #400000;
        fail("run timed out");
        print_verdict();
    end
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        apb(1'h0, `EINT_OFF_SENSE, 32'h0, 33'h0);
        apb(1'h0, `EINT_OFF_MASK, 32'h0, 33'h0);
        apb(1'h0, 12'h00C, 32'h0, 33'h100000000);
        rnd = lfsr(rnd);
        apb(1'h1, `EINT_OFF_SENSE, {rnd, rnd}, 33'h0);
        apb(1'h0, `EINT_OFF_SENSE, 32'h0, {25'h0, rnd[7:0]});
        apb(1'h1, `EINT_OFF_MASK, {rnd, rnd}, 33'h0);
        apb(1'h0, `EINT_OFF_MASK, 32'h0, {29'h0, rnd[3:0]});
        $display("test registers done");
        gie <= 1'h1;
        for (int m = 0; m < 4; m++)
        begin
            f = 4'h1 << m;
            apb(1'h1, `EINT_OFF_MASK, 32'h0, 33'h0);
            apb(1'h1, `EINT_OFF_SENSE, 32'(m) << (2 * m), 33'h0);
            apb(1'h1, `EINT_OFF_MASK, {28'h0, f}, 33'h0);
            pins[m] <= 1'h0;
            repeat (3) @(posedge clk);
            chk(0, (m != 3) ? f : 4'h0, "request after fall");
            apb(1'h0, `EINT_OFF_FLAGS, 32'h0, (m == 1 || m == 2) ? f : 4'h0);
            apb(1'h1, `EINT_OFF_FLAGS, 32'hF, 33'h0);
            pins[m] <= 1'h1;
            repeat (3) @(posedge clk);
            apb(1'h0, `EINT_OFF_FLAGS, 32'h0, (m == 1 || m == 3) ? f : 4'h0);
            chk(0, (m == 1 || m == 3) ? f : 4'h0, "request after rise");
            apb(1'h1, `EINT_OFF_FLAGS, 32'hF, 33'h0);
            apb(1'h0, `EINT_OFF_FLAGS, 32'h0, 33'h0);
        end
        $display("test sense modes done");
        apb(1'h1, `EINT_OFF_MASK, 32'h0, 33'h0);
        apb(1'h1, `EINT_OFF_SENSE, 32'h2, 33'h0);
        apb(1'h1, `EINT_OFF_MASK, 32'h1, 33'h0);
        gie <= 1'h0;
        pins[0] <= 1'h0;
        repeat (3) @(posedge clk);
        chk(1, 4'h0, "request with global enable off");
        apb(1'h0, `EINT_OFF_FLAGS, 32'h0, 33'h1);
        gie <= 1'h1;
        chk(1, 4'h9, "vector request");
        auto_en <= 1'h1;
        repeat (4) @(posedge clk);
        apb(1'h0, `EINT_OFF_FLAGS, 32'h0, 33'h0);
        auto_en <= 1'h0;
        ioclk <= 1'h0;
        pins[0] <= 1'h1;
        repeat (3) @(posedge clk);
        pins[0] <= 1'h0;
        repeat (3) @(posedge clk);
        apb(1'h0, `EINT_OFF_FLAGS, 32'h0, 33'h0);
        apb(1'h1, `EINT_OFF_MASK, 32'h0, 33'h0);
        apb(1'h1, `EINT_OFF_SENSE, 32'h0, 33'h0);
        apb(1'h1, `EINT_OFF_MASK, 32'h1, 33'h0);
        chk(0, 4'h1, "level request without I/O clock");
        $display("test enables and clock done");
        pins[0] <= 1'h1;
        pd <= 1'h1;
        @(posedge clk);
        pins[0] <= 1'h0;
        pulse_tick();
        pins[0] <= 1'h1;
        pulse_tick();
        chk(2, 4'h0, "wake after a single tick");
        pins[0] <= 1'h0;
        pulse_tick();
        pulse_tick();
        @(posedge clk);
        chk(2, 4'h1, "no wake after two ticks");
        pins[0] <= 1'h1;
        chk(0, 4'h0, "interrupt after level vanished");
        chk(2, 4'h1, "wake dropped early");
        pd <= 1'h0;
        repeat (2) @(posedge clk);
        chk(2, 4'h0, "wake not released");
        $display("test wake done");
        print_verdict();
    end
endmodule
